// File: core/soe_pkg.sv
// Shared constants for the event input configuration and status word.
package soe_pkg;
  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int SOE_ADDR_W = 8;
  localparam logic [7:0] SOE_CSR_ADDR = 8'h0D;
  localparam logic [15:0] SOE_CSR_RESET = 16'h0000;
  localparam logic [15:0] SOE_CSR_WR_MASK = 16'h3543;
  // ==========================================================================
  // Bit positions
  // ==========================================================================
  localparam int SOE_B_CONFIGURED = 0;
  localparam int SOE_B_FORCE_ERR = 1;
  localparam int SOE_B_FUSE_EN = 6;
  localparam int SOE_B_FUSE_ST = 7;
  localparam int SOE_B_CONTACT_EN = 8;
  localparam int SOE_B_AUX_ST = 9;
  localparam int SOE_B_GF_ATTN_EN = 10;
  localparam int SOE_B_GF_ST = 11;
  localparam int SOE_B_CHAT_DIS = 12;
  localparam int SOE_B_CHAT_MODE = 13;
  localparam int SOE_B_CLK_SYNC = 14;
  // ==========================================================================
  // Chatter timing
  // ==========================================================================
  localparam int SOE_CLK_HZ = 50_000_000;
  localparam int SOE_CHAT_WIN_MS = 100;
  localparam int SOE_CHAT_WIN_CYC = (SOE_CLK_HZ / 1000) * SOE_CHAT_WIN_MS;
  localparam logic [2:0] SOE_CHAT_BURST = 3'd4;
  localparam logic [2:0] SOE_CHAT_RATE = 3'd2;
endpackage : soe_pkg

// File: core/soe_sync.sv
// Two-flop synchroniser for field-side level signals.
`timescale 1ns/1ps
module soe_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule : soe_sync

// File: core/soe_csr_top.sv
// Configuration/status word, field status gating and chatter flagging.
`timescale 1ns/1ps
module soe_csr_top
  import soe_pkg::*;
#(
  parameter int NUM_CH = 16,
  parameter int WIN_CYC = SOE_CHAT_WIN_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [SOE_ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  output logic rdata_valid_o,
  input wire logic fuse_blown_i,
  input wire logic aux_fail_i,
  input wire logic gnd_fault_i,
  input wire logic clk_synced_i,
  input wire logic [NUM_CH-1:0] chan_i,
  input wire logic event_read_i,
  output logic operational_o,
  output logic internal_error_o,
  output logic attention_o,
  output logic gf_sense_en_o,
  output logic [NUM_CH-1:0] chatter_o
);
  // ==========================================================================
  // Field input synchronisation
  // ==========================================================================
  logic [NUM_CH+3:0] field_s;
  logic fuse_s, aux_s, gf_s, sync_s;
  logic [NUM_CH-1:0] chan_s;

  soe_sync #(.WIDTH(NUM_CH + 4)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i({chan_i, clk_synced_i, gnd_fault_i, aux_fail_i, fuse_blown_i}),
    .sync_o(field_s)
  );
  assign fuse_s = field_s[0];
  assign aux_s = field_s[1];
  assign gf_s = field_s[2];
  assign sync_s = field_s[3];
  assign chan_s = field_s[NUM_CH+3:4];

  function automatic logic [2:0] sat_inc(input logic [2:0] v, input logic inc);
    sat_inc = (inc && v != 3'd7) ? 3'(v + 3'd1) : v;
  endfunction : sat_inc

  // ==========================================================================
  // Register access
  // ==========================================================================
  logic hit;
  logic [15:0] cfg_reg, cfg_next;
  logic [15:0] rdata_next, status_word;
  logic rdv_next, oper_next, ierr_next, attn_next, gfen_next;
  logic fuse_st, aux_st, gf_st;

  assign hit = (addr_i == SOE_CSR_ADDR);

  always_comb begin
    cfg_next = cfg_reg;
    // Unused positions are dropped, so a careless write cannot set them.
    if (wr_i && hit) begin
      cfg_next = wdata_i & SOE_CSR_WR_MASK;
    end
    fuse_st = cfg_reg[SOE_B_FUSE_EN] & fuse_s;
    aux_st = cfg_reg[SOE_B_CONTACT_EN] & aux_s;
    gf_st = cfg_reg[SOE_B_CONTACT_EN] & gf_s;
    status_word = cfg_reg;
    status_word[SOE_B_FUSE_ST] = fuse_st;
    status_word[SOE_B_AUX_ST] = aux_st;
    status_word[SOE_B_GF_ST] = gf_st;
    status_word[SOE_B_CLK_SYNC] = sync_s;
    status_word[15] = 1'b0;
    rdv_next = rd_i;
    // Other addresses belong to neighbouring blocks; this one answers zero.
    rdata_next = (rd_i && hit) ? status_word : 16'h0000;
    oper_next = cfg_next[SOE_B_CONFIGURED];
    ierr_next = cfg_next[SOE_B_FORCE_ERR];
    gfen_next = cfg_next[SOE_B_CONTACT_EN];
    attn_next = cfg_reg[SOE_B_CONFIGURED] & (fuse_st | aux_st
                | (gf_st & cfg_reg[SOE_B_GF_ATTN_EN]));
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg <= SOE_CSR_RESET;
      rdata_o <= 16'h0000;
      rdata_valid_o <= 1'b0;
      operational_o <= 1'b0;
      internal_error_o <= 1'b0;
      attention_o <= 1'b0;
      gf_sense_en_o <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      rdata_o <= rdata_next;
      rdata_valid_o <= rdv_next;
      operational_o <= oper_next;
      internal_error_o <= ierr_next;
      attention_o <= attn_next;
      gf_sense_en_o <= gfen_next;
    end
  end

  // ==========================================================================
  // Chatter detection
  // ==========================================================================
  // The window is a free-running frame, not a sliding one, so two changes
  // straddling a frame edge can escape; this keeps one counter for all inputs.
  logic [31:0] win_reg, win_next;
  logic win_end;
  logic [NUM_CH-1:0] prev_reg, prev_next, chat_reg, chat_next;
  logic [2:0] cnt_reg [NUM_CH], cnt_next [NUM_CH];

  always_comb begin
    logic clr;
    logic [2:0] c;
    clr = 1'b0;
    c = 3'd0;
    win_end = (win_reg == 32'(WIN_CYC - 1));
    win_next = win_end ? 32'd0 : 32'(win_reg + 32'd1);
    prev_next = chan_s;
    for (int i = 0; i < NUM_CH; i++) begin
      clr = cfg_reg[SOE_B_CHAT_MODE] ? event_read_i : win_end;
      c = sat_inc(clr ? 3'd0 : cnt_reg[i], chan_s[i] ^ prev_reg[i]);
      cnt_next[i] = c;
      chat_next[i] = chat_reg[i] & ~event_read_i;
      // In mode zero a change in the read cycle still flags: the set wins.
      // Only a fresh change sets a flag, so a read clears it even while the count stands.
      if (cfg_reg[SOE_B_CONFIGURED] && !cfg_reg[SOE_B_CHAT_DIS] &&
          (chan_s[i] ^ prev_reg[i]) &&
          (cfg_reg[SOE_B_CHAT_MODE] ? c >= SOE_CHAT_BURST : c >= SOE_CHAT_RATE)) begin
        chat_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      win_reg <= 32'd0;
      prev_reg <= '0;
      chat_reg <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        cnt_reg[i] <= 3'd0;
      end
    end else begin
      win_reg <= win_next;
      prev_reg <= prev_next;
      chat_reg <= chat_next;
      for (int i = 0; i < NUM_CH; i++) begin
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  assign chatter_o = chat_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_csr_write;
    wr_i && hit;
  endsequence
  sequence s_csr_read;
    rd_i && hit && !wr_i;
  endsequence

  property p_csr_store;
    s_csr_write |=> cfg_reg == ($past(wdata_i) & SOE_CSR_WR_MASK);
  endproperty
  a_csr_store: assert property (p_csr_store) else $error("csr write not stored");

  property p_unmapped_zero;
    rd_i && !hit |=> rdata_valid_o && rdata_o == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

  property p_cfg_echo;
    s_csr_write ##2 s_csr_read |=>
      rdata_o[SOE_B_CONFIGURED] == $past(wdata_i[SOE_B_CONFIGURED], 3) &&
      rdata_o[SOE_B_CONFIGURED] == operational_o;
  endproperty
  a_cfg_echo: assert property (p_cfg_echo) else $error("configured echo wrong");

  property p_idle_quiet;
    !cfg_reg[SOE_B_CONFIGURED] |=> !attention_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("attention unconfigured");

  property p_force_err;
    s_csr_write ##1 1'b1 |-> internal_error_o == $past(wdata_i[SOE_B_FORCE_ERR]);
  endproperty
  a_force_err: assert property (p_force_err) else $error("forced error wrong");

  property p_fuse_ignored;
    (s_csr_read and !cfg_reg[SOE_B_FUSE_EN]) |=> !rdata_o[SOE_B_FUSE_ST];
  endproperty
  a_fuse_ignored: assert property (p_fuse_ignored) else $error("fuse not ignored");

  property p_gf_gated;
    (s_csr_read and !cfg_reg[SOE_B_CONTACT_EN]) |=>
      !rdata_o[SOE_B_GF_ST] && !rdata_o[SOE_B_AUX_ST];
  endproperty
  a_gf_gated: assert property (p_gf_gated) else $error("contact status not gated");

  property p_unused_zero;
    s_csr_read |=> rdata_o[15] == 1'b0 && rdata_o[5:2] == 4'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits nonzero");

  property p_chat_off;
    cfg_reg[SOE_B_CHAT_DIS] && !chatter_o[0] |=> !chatter_o[0];
  endproperty
  a_chat_off: assert property (p_chat_off) else $error("chatter flagged while off");
endmodule : soe_csr_top

// File: sim/soe_ctl_model.sv
// Controller model that issues word writes and reads on the I/O bus.
`timescale 1ns/1ps
module soe_ctl_model
  import soe_pkg::*;
(
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  input wire logic rdata_valid_i,
  output logic [SOE_ADDR_W-1:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [15:0] wdata_o
);
  initial begin
    addr_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // ==========================================================================
  // Bus cycles
  // ==========================================================================
  // Strobes last one edge; idle data shows the inverse so stale values never match.
  task automatic write_word(input logic [SOE_ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : write_word
  // A missing valid pulse returns unknown, which fails any comparison.
  task automatic read_word(input logic [SOE_ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    // The answer is registered on this edge and is taken at the next one.
    @(posedge clk_i);
    d = (rdata_valid_i === 1'b1) ? rdata_i : 16'hxxxx;
  endtask : read_word
endmodule : soe_ctl_model

// File: sim/tb_top.sv
// Self-checking testbench for the configuration and status word.
`timescale 1ns/1ps
module tb_top
  import soe_pkg::*;
;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [SOE_ADDR_W-1:0] addr;
  logic wr, rd, rv, fuse = 1'b0, aux = 1'b0, gf = 1'b0, syn = 1'b0, evr = 1'b0;
  logic op, ie, att, gfe;
  logic [15:0] wdata, rdata, chat;
  logic [15:0] chan = 16'h0000;
  int error_cnt = 0;
  int samples_checked = 0;
  always #10 clk_i = ~clk_i;
  soe_ctl_model soe_ctl_model_i (.clk_i(clk_i), .rdata_i(rdata), .rdata_valid_i(rv),
    .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  soe_csr_top #(.NUM_CH(16), .WIN_CYC(64)) soe_csr_top_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata),
    .rdata_valid_o(rv), .fuse_blown_i(fuse), .aux_fail_i(aux), .gnd_fault_i(gf),
    .clk_synced_i(syn), .chan_i(chan), .event_read_i(evr), .operational_o(op),
    .internal_error_o(ie), .attention_o(att), .gf_sense_en_o(gfe), .chatter_o(chat));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rdchk(input logic [SOE_ADDR_W-1:0] a, input logic [15:0] exp);
    logic [15:0] d;
    soe_ctl_model_i.read_word(a, d);
    chk("read word", exp, d);
  endtask : rdchk
  task automatic cfg(input logic [15:0] v);
    soe_ctl_model_i.write_word(SOE_CSR_ADDR, v);
  endtask : cfg
  // Field pins pass a two-flop synchroniser, so five cycles covers the latency.
  task automatic field(input logic f, input logic a, input logic g, input logic s);
    @(posedge clk_i);
    {fuse, aux, gf, syn} <= {f, a, g, s};
    repeat (5) @(posedge clk_i);
  endtask : field
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      chan[0] <= ~chan[0];
      repeat (3) @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
  endtask : toggle
  task automatic clear_events;
    @(posedge clk_i);
    evr <= 1'b1;
    @(posedge clk_i);
    evr <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : clear_events
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset_and_mask;
    rdchk(SOE_CSR_ADDR, 16'h0000);
    chk("operational", 16'h0000, {15'h0000, op});
    cfg(16'h3543);
    rdchk(SOE_CSR_ADDR, 16'h3543);
    chk("op ie gf", 16'h0007, {13'h0000, op, ie, gfe});
    soe_ctl_model_i.write_word(8'h0E, 16'h0000);
    rdchk(SOE_CSR_ADDR, 16'h3543);
    rdchk(8'h0E, 16'h0000);
  endtask : t_reset_and_mask
  task automatic t_status;
    cfg(16'h0001);
    field(1'b1, 1'b0, 1'b0, 1'b0);
    rdchk(SOE_CSR_ADDR, 16'h0001);
    chk("attention", 16'h0000, {15'h0000, att});
    cfg(16'h0041);
    rdchk(SOE_CSR_ADDR, 16'h00C1);
    chk("attention", 16'h0001, {15'h0000, att});
    cfg(16'h0101);
    field(1'b0, 1'b1, 1'b1, 1'b0);
    rdchk(SOE_CSR_ADDR, 16'h0B01);
    chk("attention", 16'h0001, {15'h0000, att});
    field(1'b0, 1'b0, 1'b1, 1'b0);
    chk("attention", 16'h0000, {15'h0000, att});
    cfg(16'h0501);
    rdchk(SOE_CSR_ADDR, 16'h0D01);
    chk("attention", 16'h0001, {15'h0000, att});
    cfg(16'h0001);
    field(1'b0, 1'b0, 1'b1, 1'b1);
    rdchk(SOE_CSR_ADDR, 16'h4001);
  endtask : t_status
  // Four changes in mode zero, spread over far less than a frame, leave two in one frame.
  task automatic t_chatter;
    cfg(16'h2001);
    toggle(3);
    chk("chatter", 16'h0000, chat);
    toggle(1);
    chk("chatter", 16'h0001, chat);
    clear_events();
    chk("chatter", 16'h0000, chat);
    cfg(16'h3001);
    toggle(4);
    chk("chatter", 16'h0000, chat);
    cfg(16'h0001);
    clear_events();
    // A whole frame must pass so that counts left from the burst mode are gone.
    repeat (64) @(posedge clk_i);
    toggle(1);
    chk("chatter", 16'h0000, chat);
    toggle(3);
    chk("chatter", 16'h0001, chat);
  endtask : t_chatter
  task automatic summarize;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  initial begin
    #200us;
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset_and_mask();
    t_status();
    t_chatter();
    summarize();
  end
endmodule : tb_top
